// *** dsam_pkg.sv ***
// package for the data space access mapper: widths, address map, op codes and carriers
// assumes a 16-bit core with 24-bit program words and byte-granular data addresses
package dsam_pkg;

  // ***********************************************
  // widths
  // ***********************************************
  localparam int EA_W   = 16;   // byte effective address width
  localparam int PA_W   = 24;   // program address width
  localparam int DW     = 16;   // data word width
  localparam int PW     = 24;   // program word width
  localparam int PAGE_W = 8;    // page register width
  localparam int WOFS_W = 15;   // window offset bits passed straight through

  // ***********************************************
  // field positions
  // ***********************************************
  localparam int WIN_BIT  = 15; // effective address msb selecting the upper half
  localparam int BSEL_BIT = 0;  // byte select bit of the effective address

  // ***********************************************
  // fixed address map and constant values
  // ***********************************************
  localparam logic [EA_W-1:0]   Y_BASE     = 16'h1800; // first Y space byte
  localparam logic [EA_W-1:0]   Y_LAST     = 16'h1fff; // last Y space byte
  localparam logic [EA_W-1:0]   IMPL_LAST  = 16'h27ff; // last implemented data byte
  localparam logic [EA_W-1:0]   MOD_STEP   = 16'h0002; // word step for modulo wrap
  localparam logic [DW-1:0]     DATA_ZERO  = 16'h0000;
  localparam logic [7:0]        BYTE_ZERO  = 8'h00;
  localparam logic [1:0]        LANES_BOTH = 2'h3;
  localparam logic [1:0]        LANE_LOW   = 2'h1;
  localparam logic [1:0]        LANE_HIGH  = 2'h2;
  localparam logic [1:0]        STALL_NONE = 2'h0;
  localparam logic [1:0]        STALL_ONE  = 2'h1;
  localparam logic [1:0]        STALL_TWO  = 2'h2;

  // ***********************************************
  // operation kinds and instruction classes
  // ***********************************************
  typedef enum logic [6:0] {
    OP_RD   = 7'h01,  // plain data read
    OP_WR   = 7'h02,  // plain data write, incl. accumulator write-back
    OP_TRDL = 7'h04,  // table_read_low_op
    OP_TRDH = 7'h08,  // table_read_high_op
    OP_TWRL = 7'h10,  // table_write_low_op (mapping only)
    OP_TWRH = 7'h20,  // table_write_high_op (mapping only)
    OP_MAC  = 7'h40   // multiply_accumulate_class dual read
  } dsam_op_t;

  typedef enum logic [1:0] {
    IC_MACPF = 2'h0,  // multiply_accumulate_class with operand prefetch
    IC_MOV   = 2'h1,  // single move
    IC_MOVD  = 2'h2,  // double_move_op
    IC_OTHER = 2'h3
  } dsam_icls_t;

  // ***********************************************
  // carriers
  // ***********************************************
  typedef struct packed {
    logic            valid;
    dsam_op_t        op;
    logic            byteOp;
    dsam_icls_t      icls;
    logic [EA_W-1:0] ea;        // x side address
    logic [EA_W-1:0] yEa;       // y side address, multiply_accumulate_class only
    logic            xPtrOk;    // x address came from x_pointer_a or x_pointer_b
    logic            yPtrOk;    // y address came from y_pointer_a or y_pointer_b
    logic            bitRev;
    logic            moduloEn;
    logic [EA_W-1:0] modStart;
    logic [EA_W-1:0] modEnd;
    logic [DW-1:0]   wrData;
  } dsam_req_t;

  typedef struct packed {
    logic inRepeat;
    logic firstIter;
    logic lastIter;
    logic intExit;
    logic reentry;
  } dsam_rpt_t;

  typedef struct packed {
    logic              windowEnable; // program_space_window bit of core_control_register
    logic [PAGE_W-1:0] windowPage;   // window_page_register
    logic [PAGE_W-1:0] tablePage;    // table_page_register
    logic              tableBusy;
  } dsam_ctl_t;

  typedef struct packed {
    logic            rd;
    logic [PA_W-1:0] addr;
  } dsam_pmem_t;

  typedef struct packed {
    logic            rd;
    logic            wr;
    logic [EA_W-1:0] addr;
    logic [1:0]      byteEn;
    logic [DW-1:0]   wrData;
  } dsam_xmem_t;

  typedef struct packed {
    logic            rd;
    logic [EA_W-1:0] addr;
  } dsam_ymem_t;

endpackage : dsam_pkg

// *** dsam_addr_unit.sv ***
// one address generator lane: modulo wrap, optional bit reversal, region decode
// assumes modulo bounds are word aligned and start is not above end
`timescale 1ns/10ps
`default_nettype none
module dsam_addr_unit
  import dsam_pkg::*;
#(
  parameter bit ALLOW_BREV = 1'b1,
  parameter int BREV_BITS  = 4
) (
  input  wire logic [EA_W-1:0] eaIn,
  input  wire logic            moduloEn,
  input  wire logic [EA_W-1:0] modStart,
  input  wire logic [EA_W-1:0] modEnd,
  input  wire logic            bitRevEn,
  output logic      [EA_W-1:0] eaOut,
  output logic                 inY,
  output logic                 implemented
);

  // ***********************************************
  // address adjust
  // ***********************************************
  logic [EA_W-1:0] modLen;
  logic [EA_W-1:0] eaMod;
  logic [EA_W-1:0] eaRev;

  // modulo wrap in either direction
  assign modLen = modEnd - modStart + MOD_STEP;
  assign eaMod  = !moduloEn ? eaIn :
                  (eaIn > modEnd)   ? eaIn - modLen :
                  (eaIn < modStart) ? eaIn + modLen : eaIn;

  // reverse the low word-index bits, byte bit kept
  always_comb begin
    eaRev = eaMod;
    for (int i = 0; i < BREV_BITS; i++) begin
      eaRev[1+i] = eaMod[BREV_BITS-i];
    end
  end

  assign eaOut       = (ALLOW_BREV && bitRevEn) ? eaRev : eaMod;
  // fixed region decode, no software control
  assign inY         = (eaOut >= Y_BASE) && (eaOut <= Y_LAST);
  assign implemented = (eaOut <= IMPL_LAST);

endmodule : dsam_addr_unit
`default_nettype wire

// *** dsam_mapper.sv ***
// data space access mapper: table reads, program space window, X/Y split
// assumes one request per accepted cycle and memories that answer in the cycle of
// their strobe; the pipeline holds a request while stall is high
`timescale 1ns/10ps
`default_nettype none
// Contract
// R1 - low word table read passes bits unchanged
// R2 - low byte table read picks byte by select
// R3 - high word read: upper byte low, zeros above
// R4 - high byte read: select one gives zero
// R5 - window only with msb and enable set
// R6 - upper half maps onto chosen program page
// R7 - window address: 15 ea bits plus page
// R8 - window returns low 16 program bits
// R9 - upper half always X, never Y
// R10 - window suspended during table access
// R11 - outside repeat: one or two stall cycles
// R12 - repeat edge iterations stall two cycles
// R13 - other repeat iterations add no stall
// R14 - multiply reads: X excludes Y region
// R15 - multiply reads use dedicated pointer pairs concurrently
// R16 - all writes go over X write bus
// R17 - bit reversal X writes; modulo both spaces
// R18 - unimplemented or misdirected reads return zero
// R19 - 16-bit byte addresses, 64 Kbyte range
// R20 - 16-bit words with addressable bytes
// R21 - X/Y boundary fixed in hardware
// R22 - bit 23 from table page only
// R23 - byte reads select with address lsb
module dsam_mapper
  import dsam_pkg::*;
#(
  parameter int BREV_BITS = 4
) (
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire dsam_req_t       req,
  input  wire dsam_rpt_t       rpt,
  input  wire dsam_ctl_t       ctl,
  input  wire logic [PW-1:0]   pmemRdData,
  input  wire logic [DW-1:0]   xRdData,
  input  wire logic [DW-1:0]   yRdData,
  output var  dsam_pmem_t      pmem_q,
  output var  dsam_xmem_t      xmem_q,
  output var  dsam_ymem_t      ymem_q,
  output logic [DW-1:0]        xData_q,
  output logic [DW-1:0]        yData_q,
  output logic                 dataValid_q,
  output logic                 stall_q
);

  // ***********************************************
  // request decode
  // ***********************************************
  logic            accept;
  logic            isTable;
  logic            isTblRd;
  logic            isRead;
  logic            isMac;
  logic [EA_W-1:0] xEa;
  logic [EA_W-1:0] yEa;
  logic            xInY;
  logic            yInY;
  logic            xImpl;
  logic            yImplUnused;

  assign accept  = req.valid && !stall_q;
  assign isTblRd = (req.op == OP_TRDL) || (req.op == OP_TRDH);
  assign isTable = isTblRd || (req.op == OP_TWRL) || (req.op == OP_TWRH);
  assign isMac   = (req.op == OP_MAC);
  assign isRead  = (req.op == OP_RD) || isMac;

  // x lane: bit reversal honoured on writes only [R17]
  dsam_addr_unit #(
    .ALLOW_BREV (1'b1),
    .BREV_BITS  (BREV_BITS)
  ) u_xLane (
    .eaIn        (req.ea),
    .moduloEn    (req.moduloEn),
    .modStart    (req.modStart),
    .modEnd      (req.modEnd),
    .bitRevEn    (req.bitRev && (req.op == OP_WR)),
    .eaOut       (xEa),
    .inY         (xInY),
    .implemented (xImpl)
  );

  // y lane: modulo only, never bit reversed [R17]
  dsam_addr_unit #(
    .ALLOW_BREV (1'b0),
    .BREV_BITS  (BREV_BITS)
  ) u_yLane (
    .eaIn        (req.yEa),
    .moduloEn    (req.moduloEn),
    .modStart    (req.modStart),
    .modEnd      (req.modEnd),
    .bitRevEn    (1'b0),
    .eaOut       (yEa),
    .inY         (yInY),
    .implemented (yImplUnused)
  );

  // ***********************************************
  // program space window and table addressing
  // ***********************************************
  logic            winHit;
  logic [PA_W-1:0] winAddr;
  logic [PA_W-1:0] tblAddr;

  // msb and enable, suspended during table traffic [R5] [R10]
  assign winHit  = isRead && xEa[WIN_BIT] && ctl.windowEnable
                   && !isTable && !ctl.tableBusy;
  // page on top of 15 direct bits, bit 23 clear [R6] [R7] [R22]
  assign winAddr = {1'b0, ctl.windowPage, xEa[WOFS_W-1:0]};
  // table page supplies bits 23..16, bit 23 picks config space [R22]
  assign tblAddr = {ctl.tablePage, xEa};

  // ***********************************************
  // invalid access detection
  // ***********************************************
  logic macXBad;
  logic macYBad;
  logic zeroX;
  logic zeroY;

  // x operand must miss the Y region and use an x pointer [R14] [R15]
  assign macXBad = isMac && (!req.xPtrOk || xInY);
  // y operand must be inside Y, upper half never qualifies [R9] [R15] [R21]
  assign macYBad = isMac && (!req.yPtrOk || !yInY);
  // unimplemented address outside the window reads as zero [R18] [R19]
  assign zeroX   = (!xImpl && !winHit) || macXBad;
  assign zeroY   = macYBad;

  // ***********************************************
  // memory strobes
  // ***********************************************
  logic            progRd;
  logic            dataRd;
  logic            dataWr;
  logic            yRd;
  logic [1:0]      lanes;
  logic [DW-1:0]   wrWord;

  assign progRd = accept && (isTblRd || winHit);
  assign dataRd = accept && isRead && !winHit && !zeroX;
  // every write on the x write bus, any implemented address [R16]
  assign dataWr = accept && (req.op == OP_WR) && xImpl;
  // y read issued alongside the x read [R15]
  assign yRd    = accept && isMac && !zeroY;
  // byte writes touch one lane of the 16-bit word [R20]
  assign lanes  = !req.byteOp ? LANES_BOTH :
                  xEa[BSEL_BIT] ? LANE_HIGH : LANE_LOW;
  assign wrWord = req.byteOp ? {req.wrData[7:0], req.wrData[7:0]} : req.wrData;

  // strobes and addresses toward the memories
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pmem_q <= '0;
      xmem_q <= '0;
      ymem_q <= '0;
    end else begin
      pmem_q.rd     <= progRd;
      pmem_q.addr   <= isTable ? tblAddr : winAddr; // [R22]
      xmem_q.rd     <= dataRd;
      xmem_q.wr     <= dataWr;
      xmem_q.addr   <= xEa;
      xmem_q.byteEn <= lanes;
      xmem_q.wrData <= wrWord;
      ymem_q.rd     <= yRd;
      ymem_q.addr   <= yEa;
    end
  end

  // ***********************************************
  // window stall counter
  // ***********************************************
  logic       shortClass;
  logic       rptEdge;
  logic [1:0] stallLen;
  logic [1:0] stallCnt_q;
  logic [1:0] stallCnt_d;

  assign shortClass = (req.icls == IC_MACPF) || (req.icls == IC_MOV)
                      || (req.icls == IC_MOVD);
  assign rptEdge    = rpt.firstIter || rpt.lastIter || rpt.intExit || rpt.reentry;
  // outside repeat one or two [R11]; edge iterations two [R12]; others none [R13]
  assign stallLen   = !winHit ? STALL_NONE :
                      !rpt.inRepeat ? (shortClass ? STALL_ONE : STALL_TWO) :
                      rptEdge ? STALL_TWO : STALL_NONE;
  assign stallCnt_d = accept ? stallLen :
                      (stallCnt_q != STALL_NONE) ? stallCnt_q - STALL_ONE : STALL_NONE;

  // stall stays high for exactly the counted cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stallCnt_q <= STALL_NONE;
      stall_q    <= 1'b0;
    end else begin
      stallCnt_q <= stallCnt_d;
      stall_q    <= (stallCnt_d != STALL_NONE);
    end
  end

  // ***********************************************
  // return stage bookkeeping
  // ***********************************************
  logic     stgValid_q;
  dsam_op_t stgOp_q;
  logic     stgByte_q;
  logic     stgSel_q;
  logic     stgWin_q;
  logic     stgZeroX_q;
  logic     stgZeroY_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stgValid_q <= 1'b0;
      stgOp_q    <= OP_RD;
      stgByte_q  <= 1'b0;
      stgSel_q   <= 1'b0;
      stgWin_q   <= 1'b0;
      stgZeroX_q <= 1'b0;
      stgZeroY_q <= 1'b0;
    end else begin
      stgValid_q <= accept && (isRead || isTblRd);
      stgOp_q    <= req.op;
      stgByte_q  <= req.byteOp && !isMac;
      stgSel_q   <= xEa[BSEL_BIT];
      stgWin_q   <= winHit;
      stgZeroX_q <= zeroX && !isTblRd;
      stgZeroY_q <= zeroY || !isMac; // y result only for dual reads
    end
  end

  // ***********************************************
  // data lane steering
  // ***********************************************
  logic [DW-1:0] lowWord;
  logic [7:0]    lowByte;
  logic [7:0]    highByte;
  logic [DW-1:0] dataWord;
  logic [7:0]    dataByte;
  logic [DW-1:0] xResult;

  // low program word unchanged [R1]; lower 16 bits for the window [R8]
  assign lowWord  = pmemRdData[DW-1:0];
  // byte select picks low or high lane [R2] [R23]
  assign lowByte  = stgSel_q ? pmemRdData[15:8] : pmemRdData[7:0];
  // upper program byte, zero on select one [R4]
  assign highByte = stgSel_q ? BYTE_ZERO : pmemRdData[23:16];
  assign dataWord = stgWin_q ? lowWord : xRdData;
  // whole word fetched, lsb chooses the byte [R23]
  assign dataByte = stgSel_q ? dataWord[15:8] : dataWord[7:0];

  always_comb begin
    xResult = DATA_ZERO;
    case (stgOp_q)
      OP_TRDL: xResult = stgByte_q ? {BYTE_ZERO, lowByte} : lowWord;     // [R1] [R2]
      OP_TRDH: xResult = stgByte_q ? {BYTE_ZERO, highByte}               // [R4]
                                   : {BYTE_ZERO, pmemRdData[23:16]};      // [R3]
      OP_RD,
      OP_MAC:  xResult = stgZeroX_q ? DATA_ZERO :                         // [R18]
                         stgByte_q  ? {BYTE_ZERO, dataByte} : dataWord;
      default: xResult = DATA_ZERO;
    endcase
  end

  // results registered one cycle after the memory strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xData_q     <= DATA_ZERO;
      yData_q     <= DATA_ZERO;
      dataValid_q <= 1'b0;
    end else begin
      dataValid_q <= stgValid_q;
      if (stgValid_q) begin
        xData_q <= xResult;
        yData_q <= stgZeroY_q ? DATA_ZERO : yRdData; // [R18]
      end
    end
  end

  // ***********************************************
  // checks
  // ***********************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_trdl_word;
    (stgValid_q && stgOp_q == OP_TRDL && !stgByte_q)
      |=> xData_q == $past(pmemRdData[15:0]);
  endproperty
  a_trdl_word: assert property (p_trdl_word) else $error("low word table read altered"); // [R1]

  property p_trdl_byte;
    (accept && req.op == OP_TRDL && req.byteOp && req.ea[BSEL_BIT])
      ##1 stgValid_q |=> xData_q == {BYTE_ZERO, $past(pmemRdData[15:8])};
  endproperty
  a_trdl_byte: assert property (p_trdl_byte) else $error("low byte table read lane wrong"); // [R2]

  property p_trdh_word;
    (stgValid_q && stgOp_q == OP_TRDH && !stgByte_q)
      |=> (xData_q[15:8] == BYTE_ZERO) && (xData_q[7:0] == $past(pmemRdData[23:16]));
  endproperty
  a_trdh_word: assert property (p_trdh_word) else $error("high word table read wrong"); // [R3]

  property p_trdh_byte;
    (accept && req.op == OP_TRDH && req.byteOp && req.ea[BSEL_BIT])
      |=> ##1 xData_q == DATA_ZERO;
  endproperty
  a_trdh_byte: assert property (p_trdh_byte) else $error("high byte select one not zero"); // [R4]

  property p_win_addr;
    (accept && req.op == OP_RD && xEa[WIN_BIT] && ctl.windowEnable && !ctl.tableBusy)
      |=> pmem_q.rd && !xmem_q.rd
          && pmem_q.addr == {1'b0, $past(ctl.windowPage), $past(xEa[WOFS_W-1:0])};
  endproperty
  a_win_addr: assert property (p_win_addr) else $error("window address wrong"); // [R7]

  property p_win_off;
    (accept && !isTblRd && (!ctl.windowEnable || ctl.tableBusy)) |=> !pmem_q.rd;
  endproperty
  a_win_off: assert property (p_win_off) else $error("window used while disabled"); // [R10]

  property p_stall_two;
    (accept && winHit && !rpt.inRepeat && req.icls == IC_OTHER)
      |=> stall_q [*2] ##1 !stall_q;
  endproperty
  a_stall_two: assert property (p_stall_two) else $error("window stall not two cycles"); // [R11]

  property p_stall_rpt_mid;
    (accept && winHit && rpt.inRepeat && !rptEdge) |=> !stall_q;
  endproperty
  a_stall_rpt_mid: assert property (p_stall_rpt_mid) else $error("stall in mid iteration"); // [R13]

  property p_y_upper;
    (accept && isMac && yEa[WIN_BIT]) |=> !ymem_q.rd ##1 yData_q == DATA_ZERO;
  endproperty
  a_y_upper: assert property (p_y_upper) else $error("upper half read via y lane"); // [R9]

  property p_bit23;
    (accept && !isTable) |=> pmem_q.addr[PA_W-1] == 1'b0;
  endproperty
  a_bit23: assert property (p_bit23) else $error("bit 23 set outside table access"); // [R22]

endmodule : dsam_mapper
`default_nettype wire

// *** dsam_mem_model.sv ***
// memory model for the mapper's program, x and y ports
// assumes one-cycle strobes with data sampled in the strobe cycle
`timescale 1ns/10ps
`default_nettype none
module dsam_mem_model
  import dsam_pkg::*;
(
  input  wire logic       clk,
  input  wire dsam_pmem_t pmem_q,
  input  wire dsam_xmem_t xmem_q,
  input  wire dsam_ymem_t ymem_q,
  output logic [PW-1:0]   pmemRdData,
  output logic [DW-1:0]   xRdData,
  output logic [DW-1:0]   yRdData
);
  // contents derived from the word address
  function automatic logic [PW-1:0] pw(input logic [PA_W-1:0] a);
    return {a[8:1] ^ a[23:16], a[16:1] ^ 16'h5aa5};
  endfunction : pw
  function automatic logic [DW-1:0] xw(input logic [EA_W-1:0] a);
    return {a[15:1], 1'b0} ^ 16'hc3c3;
  endfunction : xw
  function automatic logic [DW-1:0] yw(input logic [EA_W-1:0] a);
    return {a[15:1], 1'b0} ^ 16'h7e81;
  endfunction : yw
  logic [PW-1:0] pLast = '0;
  logic [DW-1:0] xLast = '0;
  logic [DW-1:0] yLast = '0;
  // outside a strobe the bus shows the inverse of the last word
  assign pmemRdData = pmem_q.rd ? pw(pmem_q.addr) : ~pLast;
  assign xRdData    = xmem_q.rd ? xw(xmem_q.addr) : ~xLast;
  assign yRdData    = ymem_q.rd ? yw(ymem_q.addr) : ~yLast;
  // remember the last word handed out
  always @(posedge clk) begin
    if (pmem_q.rd) pLast <= pmemRdData;
    if (xmem_q.rd) xLast <= xRdData;
    if (ymem_q.rd) yLast <= yRdData;
  end
endmodule : dsam_mem_model
`default_nettype wire

// *** dsam_mapper_tb.sv ***
// self-checking bench for the mapper with a memory model
// assumes registered strobes and results two edges after accept
`timescale 1ns/10ps
`default_nettype none
module dsam_mapper_tb
  import dsam_pkg::*;
;
  logic clk, reset_n, dataValid_q, stall_q;
  dsam_req_t req;
  dsam_rpt_t rpt;
  dsam_ctl_t ctl;
  dsam_pmem_t pmem_q;
  dsam_xmem_t xmem_q;
  dsam_ymem_t ymem_q;
  logic [PW-1:0] pmemRdData;
  logic [DW-1:0] xRdData, yRdData, xData_q, yData_q;
  int fails = 0;
  int checks = 0;
  logic [31:0] seed = 32'hb054;

  dsam_mapper dsam_mapper_inst (.clk(clk), .reset_n(reset_n), .req(req), .rpt(rpt),
    .ctl(ctl), .pmemRdData(pmemRdData), .xRdData(xRdData), .yRdData(yRdData),
    .pmem_q(pmem_q), .xmem_q(xmem_q), .ymem_q(ymem_q), .xData_q(xData_q),
    .yData_q(yData_q), .dataValid_q(dataValid_q), .stall_q(stall_q));
  dsam_mem_model dsam_mem_model_inst (.clk(clk), .pmem_q(pmem_q), .xmem_q(xmem_q),
    .ymem_q(ymem_q), .pmemRdData(pmemRdData), .xRdData(xRdData), .yRdData(yRdData));

  // expected memory contents
  function automatic logic [PW-1:0] pw(input logic [PA_W-1:0] a);
    return {a[8:1] ^ a[23:16], a[16:1] ^ 16'h5aa5};
  endfunction : pw
  function automatic logic [DW-1:0] xw(input logic [EA_W-1:0] a);
    return {a[15:1], 1'b0} ^ 16'hc3c3;
  endfunction : xw
  function automatic logic [DW-1:0] yw(input logic [EA_W-1:0] a);
    return {a[15:1], 1'b0} ^ 16'h7e81;
  endfunction : yw
  // byte lane pick onto the low byte
  function automatic logic [DW-1:0] sel(input logic b, input logic s, input logic [DW-1:0] w);
    return b ? {8'h00, s ? w[15:8] : w[7:0]} : w;
  endfunction : sel
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic stop_test();
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one request, then strobe, result and stall count
  task automatic run(input dsam_req_t r, input dsam_ctl_t c, input dsam_rpt_t p,
      input logic [DW-1:0] ex, input logic [DW-1:0] ey, input logic [PA_W-1:0] pa,
      input logic useP, input int st);
    int ns;
    logic rd;
    logic [15:0] ea;
    ns = 0;
    rd = (r.op != OP_WR);
    // write address with word-index bits [4:1] reversed when asked
    ea = r.bitRev ? {r.ea[15:5], r.ea[1], r.ea[2], r.ea[3], r.ea[4], r.ea[0]} : r.ea;
    @(negedge clk);
    req = r;
    ctl = c;
    rpt = p;
    // strobes stand in the cycle after the accepting edge
    @(negedge clk);
    req.valid = 1'b0;
    if (stall_q === 1'b1) ns++;
    if (useP) chk({pmem_q.rd, pmem_q.addr}, {1'b1, pa});
    if (!rd) begin
      chk({xmem_q.wr, ymem_q.rd, xmem_q.addr[15:1], xmem_q.byteEn}, {2'h2, ea[15:1],
        r.byteOp ? (r.ea[0] ? 2'h2 : 2'h1) : 2'h3});
      chk(xmem_q.wrData, r.byteOp ? {2{r.wrData[7:0]}} : r.wrData);
    end
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      #1;
      if (stall_q === 1'b1) ns++;
      if (i == 0) chk(dataValid_q, rd);
      if (i == 0 && rd) chk({xData_q, yData_q}, {ex, ey});
    end
    chk(ns, st);
  endtask : run

  // plain word read with chosen window controls
  task automatic rd1(input logic [15:0] ea, input logic en, input logic busy,
      input logic [15:0] ex);
    dsam_req_t r;
    dsam_ctl_t c;
    r = '0;
    r.valid = 1'b1;
    r.op = OP_RD;
    r.ea = ea;
    c = '0;
    c.windowEnable = en;
    c.tableBusy = busy;
    run(r, c, '0, ex, 16'h0000, '0, 1'b0, 0);
  endtask : rd1

  // dual read, window enabled on page 3c
  task automatic mac(input logic [15:0] x, input logic [15:0] y, input logic xo,
      input logic yo, input logic xv, input logic yv);
    dsam_req_t r;
    dsam_ctl_t c;
    logic [PA_W-1:0] a;
    logic [PW-1:0] w;
    r = '0;
    r.valid = 1'b1;
    r.op = OP_MAC;
    r.icls = IC_MACPF;
    r.ea = x;
    r.yEa = y;
    r.xPtrOk = xo;
    r.yPtrOk = yo;
    c = '0;
    c.windowEnable = 1'b1;
    c.windowPage = 8'h3c;
    a = {1'b0, 8'h3c, x[14:0]};
    w = pw(a);
    run(r, c, '0, x[15] ? w[15:0] : (xv ? xw(x) : 16'h0000), yv ? yw(y) : 16'h0000,
      a, x[15], x[15] ? 1 : 0);
  endtask : mac

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    dsam_req_t r;
    dsam_ctl_t c;
    dsam_rpt_t p;
    logic [PA_W-1:0] a;
    logic [PW-1:0] w;
    logic [31:0] v;
    logic [DW-1:0] ex;
    int m;
    req = '0;
    rpt = '0;
    ctl = '0;
    reset_n = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    // table reads, all kinds, window on or busy
    for (int k = 0; k < 16; k++) begin
      v = xs();
      r = '0;
      r.valid = 1'b1;
      r.op = k[0] ? OP_TRDH : OP_TRDL;
      r.byteOp = k[1];
      r.ea = v[15:0] & (k[1] ? 16'hffff : 16'hfffe);
      c = '0;
      c.windowEnable = k[2];
      c.tableBusy = k[3];
      c.tablePage = v[23:16];
      a = {c.tablePage, r.ea};
      w = pw(a);
      ex = k[0] ? {8'h00, (k[1] && r.ea[0]) ? 8'h00 : w[23:16]} : sel(k[1], r.ea[0], w[15:0]);
      run(r, c, '0, ex, 16'h0000, a, 1'b1, 0);
    end
    // window reads over classes and repeat cases
    for (int k = 0; k < 24; k++) begin
      v = xs();
      m = k / 4;
      r = '0;
      r.valid = 1'b1;
      r.op = OP_RD;
      r.icls = dsam_icls_t'(k[1:0]);
      r.byteOp = v[16];
      r.ea = {1'b1, v[14:1], v[0] & v[16]};
      c = '0;
      c.windowEnable = 1'b1;
      c.windowPage = v[31:24];
      p = '0;
      p.inRepeat = (m != 0);
      p.firstIter = (m == 2);
      p.lastIter = (m == 3);
      p.intExit = (m == 4);
      p.reentry = (m == 5);
      a = {1'b0, c.windowPage, r.ea[14:0]};
      w = pw(a);
      run(r, c, p, sel(r.byteOp, r.ea[0], w[15:0]), 16'h0000, a, 1'b1,
        (m == 0) ? ((k[1:0] == 2'h3) ? 2 : 1) : ((m == 1) ? 0 : 2));
    end
    // plain reads in the implemented range, then at and past its end
    for (int k = 0; k < 8; k++) begin
      v = xs();
      r = '0;
      r.valid = 1'b1;
      r.op = OP_RD;
      r.icls = IC_MOV;
      r.byteOp = v[16];
      r.bitRev = v[18];
      r.ea = (v[15:0] % 16'h2800) & {15'h7fff, v[16]};
      c = '0;
      c.windowEnable = v[17];
      run(r, c, '0, sel(r.byteOp, r.ea[0], xw(r.ea)), 16'h0000, '0, 1'b0, 0);
    end
    rd1(16'h27fe, 1'b0, 1'b0, xw(16'h27fe));
    rd1(16'h2800, 1'b1, 1'b0, 16'h0000);
    rd1(16'h8000, 1'b0, 1'b0, 16'h0000);
    rd1(16'hfffe, 1'b1, 1'b1, 16'h0000);
    // modulo wrap on the x lane, one word past the end
    r = '0;
    r.valid = 1'b1;
    r.op = OP_RD;
    r.ea = 16'h0120;
    r.moduloEn = 1'b1;
    r.modStart = 16'h0100;
    r.modEnd = 16'h011e;
    run(r, '0, '0, xw(16'h0100), 16'h0000, '0, 1'b0, 0);
    // dual reads, valid and misdirected pointers
    mac(16'h0100, 16'h1800, 1'b1, 1'b1, 1'b1, 1'b1);
    mac(16'h1900, 16'h1802, 1'b1, 1'b1, 1'b0, 1'b1);
    mac(16'h0200, 16'h1ffe, 1'b0, 1'b1, 1'b0, 1'b1);
    mac(16'h0204, 16'h0400, 1'b1, 1'b1, 1'b1, 1'b0);
    mac(16'h0206, 16'h1804, 1'b1, 1'b0, 1'b1, 1'b0);
    mac(16'h2800, 16'h8000, 1'b1, 1'b1, 1'b0, 1'b0);
    mac(16'h8010, 16'h1806, 1'b1, 1'b1, 1'b1, 1'b1);
    // writes, word and byte, one into the y region
    for (int k = 0; k < 8; k++) begin
      v = xs();
      r = '0;
      r.valid = 1'b1;
      r.op = OP_WR;
      r.byteOp = k[0];
      r.bitRev = k[1];
      r.ea = (k == 0) ? 16'h1800 : ((v[15:0] % 16'h2800) & {15'h7fff, k[0]});
      r.wrData = v[31:16];
      run(r, '0, '0, 16'h0000, 16'h0000, '0, 1'b0, 0);
    end
    stop_test();
  end
endmodule : dsam_mapper_tb
`default_nettype wire
